/* verilog/vtr_map.vh */
// Register map, field positions and timing counts of the vector table relocation block
`ifndef VTR_MAP_VH
`define VTR_MAP_VH

`define VTR_OFF_GIC 4'h0
`define VTR_OFF_STATUS 4'h4
`define VTR_OFF_CORE 4'h8

`define VTR_BIT_CHG 0
`define VTR_BIT_SEL 1
`define VTR_BIT_IRQ2 5
`define VTR_BIT_IRQ0 6
`define VTR_BIT_IRQ1 7
`define VTR_GIC_WMASK 8'he3
`define VTR_GIC_RESET 8'h00

`define VTR_WINDOW_CYCLES 3'h4
`define VTR_VEC_BASE 14'h0002
`define VTR_VEC_STEP 14'h0002
`define VTR_BOOT_4K 14'h3800
`define VTR_BOOT_2K 14'h3c00
`define VTR_BOOT_1K 14'h3e00
`define VTR_BOOT_512 14'h3f00

`endif

/* verilog/vtr_addr_gen.v */
// Boot start decode and vector address computation
`timescale 1ns/1ns
module vtr_addr_gen (
    // Fuses and selection
    input wire [1:0] boot_size_fuses,
    input wire boot_reset_fuse,
    input wire vector_relocation_select,
    input wire [4:0] vector_index,
    // Results
    output reg [13:0] boot_start,
    output wire [13:0] reset_addr,
    output wire [13:0] table_base,
    output wire [13:0] vector_addr
);
`include "vtr_map.vh"

    always @* begin
        case (boot_size_fuses)
            2'h0: boot_start = `VTR_BOOT_4K;
            2'h1: boot_start = `VTR_BOOT_2K;
            2'h2: boot_start = `VTR_BOOT_1K;
            default: boot_start = `VTR_BOOT_512;
        endcase
    end

    assign reset_addr = boot_reset_fuse ? 14'h0000 : boot_start;
    assign table_base = vector_relocation_select ? boot_start : 14'h0000;
    assign vector_addr = table_base + `VTR_VEC_BASE + {8'h00, vector_index, 1'b0};

endmodule

/* verilog/vtr_top.v */
// Vector table relocation control with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module vtr_top (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Fuses and lock bits, 0 means programmed
    input wire boot_reset_fuse,
    input wire [1:0] boot_size_fuses,
    input wire app_section_boot_lock,
    input wire boot_section_boot_lock,
    // Core execution state
    input wire instr_done,
    input wire [13:0] exec_pc,
    input wire global_irq_enable,
    input wire [4:0] vector_index,
    // Results
    output reg irq_allowed_q,
    output reg [13:0] reset_addr_q,
    output reg [13:0] table_base_q,
    output reg [13:0] vector_addr_q,
    output reg ext_irq_zero_enable_q,
    output reg ext_irq_one_enable_q,
    output reg ext_irq_two_enable_q
);
`include "vtr_map.vh"

    ////////////////////////////////////////////////////////////////////////////////
    // Fuse and core input synchronisers
    reg [25:0] sync1_q;
    reg [25:0] sync2_q;
    wire [25:0] raw_in;
    assign raw_in = {boot_reset_fuse, boot_size_fuses, app_section_boot_lock, boot_section_boot_lock,
                     exec_pc, global_irq_enable, instr_done, vector_index};
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Fuses and lock bits come up unprogrammed in both stages, so no false programmed level follows reset
            sync1_q <= 26'h3e00000;
            sync2_q <= 26'h3e00000;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end
    wire fuse_rst = sync2_q[25];
    wire [1:0] fuse_sz = sync2_q[24:23];
    wire lock_app = sync2_q[22];
    wire lock_boot = sync2_q[21];
    wire [13:0] pc = sync2_q[20:7];
    wire gie = sync2_q[6];
    wire ins_done = sync2_q[5];
    wire [4:0] vidx = sync2_q[4:0];

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    reg [3:0] awaddr_q;
    reg aw_held_q;
    reg [7:0] wbyte_q;
    reg wstrb0_q;
    reg w_held_q;
    wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            awaddr_q <= 4'h0;
            aw_held_q <= 1'b0;
            wbyte_q <= 8'h00;
            wstrb0_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !aw_held_q && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                aw_held_q <= 1'b1;
            end
            if (s_axi_wvalid && !w_held_q && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                wbyte_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
                w_held_q <= 1'b1;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == `VTR_OFF_GIC) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    wire gic_wr = wr_fire && (awaddr_q == `VTR_OFF_GIC) && wstrb0_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register and change-enable window
    reg [7:0] gic_q;
    reg [2:0] win_q;
    reg hold_q;
    wire win_open = gic_q[`VTR_BIT_CHG];
    wire sel_write = gic_wr && win_open && !wbyte_q[`VTR_BIT_CHG];
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gic_q <= `VTR_GIC_RESET;
            win_q <= 3'h0;
            hold_q <= 1'b0;
        end else begin
            if (gic_wr) begin
                gic_q[7:5] <= wbyte_q[7:5];
            end
            if (sel_write) begin
                gic_q[`VTR_BIT_SEL] <= wbyte_q[`VTR_BIT_SEL];
                gic_q[`VTR_BIT_CHG] <= 1'b0;
                win_q <= 3'h0;
                hold_q <= 1'b1;
            end else if (gic_wr && wbyte_q[`VTR_BIT_CHG]) begin
                gic_q[`VTR_BIT_CHG] <= 1'b1;
                win_q <= `VTR_WINDOW_CYCLES;
            end else if (win_open) begin
                if (win_q == 3'h1) begin
                    gic_q[`VTR_BIT_CHG] <= 1'b0;
                end
                win_q <= win_q - 3'h1;
            end
            if (hold_q && ins_done && !sel_write) begin
                hold_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address generation and interrupt gating
    wire [13:0] boot_start;
    wire [13:0] reset_addr;
    wire [13:0] table_base;
    wire [13:0] vector_addr;
    vtr_addr_gen vtr_addr_gen_inst (
        .boot_size_fuses(fuse_sz),
        .boot_reset_fuse(fuse_rst),
        .vector_relocation_select(gic_q[`VTR_BIT_SEL]),
        .vector_index(vidx),
        .boot_start(boot_start),
        .reset_addr(reset_addr),
        .table_base(table_base),
        .vector_addr(vector_addr)
    );
    wire in_boot = pc >= boot_start;
    wire lock_block = (gic_q[`VTR_BIT_SEL] && !lock_app && !in_boot)
                   || (!gic_q[`VTR_BIT_SEL] && !lock_boot && in_boot);
    wire auto_block = win_open || (gic_wr && wbyte_q[`VTR_BIT_CHG]) || hold_q || sel_write;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_allowed_q <= 1'b0;
            reset_addr_q <= 14'h0000;
            table_base_q <= 14'h0000;
            vector_addr_q <= `VTR_VEC_BASE;
            ext_irq_zero_enable_q <= 1'b0;
            ext_irq_one_enable_q <= 1'b0;
            ext_irq_two_enable_q <= 1'b0;
        end else begin
            irq_allowed_q <= gie && !auto_block && !lock_block;
            reset_addr_q <= reset_addr;
            table_base_q <= table_base;
            vector_addr_q <= vector_addr;
            ext_irq_zero_enable_q <= gic_q[`VTR_BIT_IRQ0];
            ext_irq_one_enable_q <= gic_q[`VTR_BIT_IRQ1];
            ext_irq_two_enable_q <= gic_q[`VTR_BIT_IRQ2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            `VTR_OFF_GIC: rd_mux = {24'h000000, gic_q & `VTR_GIC_WMASK};
            `VTR_OFF_STATUS: rd_mux = {18'h00000, table_base_q};
            `VTR_OFF_CORE: rd_mux = {12'h000, hold_q, win_q, irq_allowed_q, 1'b0, reset_addr_q};
            default: rd_mux = 32'h00000000;
        endcase
    end
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (s_axi_araddr == `VTR_OFF_GIC || s_axi_araddr == `VTR_OFF_STATUS ||
                                s_axi_araddr == `VTR_OFF_CORE) ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* sim/vtr_checker.sv */
// Port checker for the vector table relocation block
`timescale 1ns/1ns
module vtr_checker (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Bus
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [1:0] s_axi_rresp,
    // Results
    input wire irq_allowed_q,
    input wire [13:0] reset_addr_q,
    input wire [13:0] table_base_q,
    input wire [13:0] vector_addr_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_base_legal: assert property (table_base_q == 14'h0 || table_base_q[13:11] == 3'h7 && table_base_q[7:0] == 8'h0)
        else $error("table base outside flash start or boot start");
    a_reset_legal: assert property (reset_addr_q == 14'h0 || reset_addr_q[13:11] == 3'h7 && reset_addr_q[7:0] == 8'h0)
        else $error("reset address outside zero or boot start");
    a_vec_step: assert property (!vector_addr_q[0] && vector_addr_q != table_base_q)
        else $error("vector address not on a two word step past the base");
    a_block_start: assert property (s_axi_wvalid && s_axi_wready && s_axi_awvalid && s_axi_awaddr == 4'h0
        && s_axi_wstrb[0] && s_axi_wdata[1:0] == 2'b01 |-> ##[1:3] !irq_allowed_q)
        else $error("interrupts not blocked after change enable");
    a_block_len: assert property ($fell(irq_allowed_q) |=> !irq_allowed_q [*3])
        else $error("interrupt block shorter than four cycles");
    a_block_end: assert property ($fell(irq_allowed_q) |-> ##[1:60] irq_allowed_q)
        else $error("interrupt block never released");
    a_rd_refuse: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 4'h8 |-> s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
    a_rd_okay: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0 |-> s_axi_rresp == 2'h0)
        else $error("control register read refused");
    a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
endmodule
bind vtr_top vtr_checker vtr_checker_inst (.*);

/* sim/vtr_core_model.sv */
// Core model: retires instructions and reports where it executes
`timescale 1ns/1ns
module vtr_core_model (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Requested program counter
    input wire [13:0] pc_set,
    // To the block
    output reg instr_done,
    output reg [13:0] exec_pc,
    output reg global_irq_enable
);
    reg [1:0] cnt_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 2'h0;
            instr_done <= 1'b0;
            exec_pc <= 14'h0;
            global_irq_enable <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            instr_done <= (cnt_q == 2'h0);
            exec_pc <= pc_set;
        end
    end
endmodule

/* sim/vtr_bench.sv */
// Self-checking bench for the vector table relocation block
`timescale 1ns/1ns
module vtr_bench;
    reg clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    reg [31:0] s_axi_wdata, d;
    reg boot_reset_fuse, app_section_boot_lock, boot_section_boot_lock;
    reg [1:0] boot_size_fuses, r, b;
    reg [4:0] vector_index;
    reg [13:0] pc_set;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, instr_done, global_irq_enable;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [13:0] exec_pc, reset_addr_q, table_base_q, vector_addr_q;
    wire irq_allowed_q, ext_irq_zero_enable_q, ext_irq_one_enable_q, ext_irq_two_enable_q;
    integer error_cnt = 0, n_checks = 0;
    function [13:0] boot_at(input [1:0] k);
        case (k)
            2'h0: boot_at = 14'h3800;
            2'h1: boot_at = 14'h3c00;
            2'h2: boot_at = 14'h3e00;
            default: boot_at = 14'h3f00;
        endcase
    endfunction
    vtr_top vtr_top_inst (.*);
    vtr_core_model vtr_core_model_inst (.*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(input string n, input [31:0] got, input [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask
    task fin(input ok);
        if (!ok) begin
            error_cnt++;
            wrap_up;
        end
    endtask
    task cy(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input [31:0] v);
        integer i;
        reg ok;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        i = 0;
        ok = 1'b0;
        while (!ok && i < 40) begin
            @(posedge clk);
            i++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                ok = 1'b1;
                b = s_axi_bresp;
            end
        end
        fin(ok);
    endtask
    task rd(input [3:0] a);
        integer i;
        reg ok;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        i = 0;
        ok = 1'b0;
        while (!ok && i < 40) begin
            @(posedge clk);
            i++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                ok = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
            end
        end
        fin(ok);
    endtask
    task t_reset;
        rd(4'h0);
        chk("control", d, 32'h0);
        chk("reset", reset_addr_q, 14'h0);
        chk("vector", vector_addr_q, 14'h0002);
        $display("reset test done");
    endtask
    task t_bits;
        wr(32'hfe);
        chk("bresp", b, 2'h0);
        rd(4'h0);
        chk("control", d, 32'he0);
        chk("ext enables", {ext_irq_zero_enable_q, ext_irq_one_enable_q, ext_irq_two_enable_q}, 3'h7);
        chk("base", table_base_q, 14'h0);
        rd(4'hc);
        chk("resp", r, 2'h2);
        wr(32'h40);
        cy(2);
        chk("ext enables", {ext_irq_zero_enable_q, ext_irq_one_enable_q, ext_irq_two_enable_q}, 3'h4);
        wr(32'h0);
        $display("bits test done");
    endtask
    task t_move;
        wr(32'h1);
        chk("irq", irq_allowed_q, 1'b0);
        wr(32'h2);
        cy(8);
        chk("base", table_base_q, 14'h3800);
        chk("vector", vector_addr_q, 14'h3802);
        chk("irq", irq_allowed_q, 1'b1);
        rd(4'h4);
        chk("status", d, 32'h3800);
        rd(4'h0);
        chk("control", d, 32'h2);
        vector_index <= 5'h1;
        cy(8);
        chk("vector", vector_addr_q, 14'h3804);
        $display("move test done");
    endtask
    task t_lapse;
        wr(32'h1);
        cy(10);
        rd(4'h0);
        chk("control", d, 32'h2);
        chk("irq", irq_allowed_q, 1'b1);
        wr(32'h0);
        cy(8);
        chk("base", table_base_q, 14'h3800);
        $display("lapse test done");
    endtask
    task t_locks;
        app_section_boot_lock <= 1'b0;
        pc_set <= 14'h0100;
        cy(10);
        chk("irq", irq_allowed_q, 1'b0);
        pc_set <= 14'h3900;
        cy(10);
        chk("irq", irq_allowed_q, 1'b1);
        app_section_boot_lock <= 1'b1;
        wr(32'h1);
        wr(32'h0);
        boot_section_boot_lock <= 1'b0;
        cy(10);
        chk("irq", irq_allowed_q, 1'b0);
        chk("base", table_base_q, 14'h0);
        pc_set <= 14'h0;
        cy(10);
        chk("irq", irq_allowed_q, 1'b1);
        boot_section_boot_lock <= 1'b1;
        $display("lock test done");
    endtask
    task t_fuse;
        integer k;
        boot_reset_fuse <= 1'b0;
        for (k = 3; k >= 0; k = k - 1) begin
            boot_size_fuses <= k[1:0];
            cy(8);
            chk("reset", reset_addr_q, boot_at(k[1:0]));
        end
        chk("vector", vector_addr_q, 14'h0004);
        rd(4'h8);
        chk("core reset", d[13:0], 14'h3800);
        wr(32'h1);
        wr(32'h2);
        cy(8);
        chk("vector", vector_addr_q, 14'h3804);
        $display("fuse test done");
    endtask
    initial begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        {boot_size_fuses, vector_index, pc_set} = 0;
        {s_axi_bready, s_axi_rready, boot_reset_fuse, app_section_boot_lock, boot_section_boot_lock} = 5'h1f;
        s_axi_wstrb = 4'hf;
        cy(10);
        resetn <= 1'b1;
        t_reset;
        t_bits;
        t_move;
        t_lapse;
        t_locks;
        t_fuse;
        wrap_up;
    end
endmodule
